// File: core/cwrs_defines.svh
// Offsets, field positions, entry addresses and timing counts of the wake and reset supervisor
`ifndef CWRS_DEFINES_SVH
`define CWRS_DEFINES_SVH
`define CWRS_ROM_ENTRY        16'hF000
`define CWRS_USER_ENTRY       16'h0030
`define CWRS_OFF_CTRL         8'h00
`define CWRS_OFF_CFG0         8'h04
`define CWRS_OFF_CFG1         8'h08
`define CWRS_OFF_STATUS       8'h0C
`define CWRS_OFF_RTC          8'h10
`define CWRS_OFF_WDOG         8'h14
`define CWRS_OFF_PC           8'h18
`define CWRS_CTRL_CFG_COPY    0
`define CWRS_CTRL_RST_USER    1
`define CWRS_CTRL_MEAS_USER   2
`define CWRS_CTRL_WDOG_OFF    3
`define CWRS_CTRL_CLR_WDOG    4
`define CWRS_CFG1_SLEEP       17
`define CWRS_CFG0_CONV_LO     16
`define CWRS_ST_SLEEP_WAKE    22
`define CWRS_ST_RESET_CAUSE   19
`define CWRS_ST_BUTTON        18
`define CWRS_ST_WDOG          17
`define CWRS_ST_MEAS_END      16
`define CWRS_WDOG_LIMIT       3'h4
`define CWRS_PRESCALE         64
`define CWRS_RTC_TICKS        128
`endif

// File: core/cwrs_pkg.sv
// Types shared by the wake and reset supervisor
package cwrs_pkg;
  typedef enum logic [2:0] {
    CWRS_IDLE, CWRS_ROM, CWRS_CFG, CWRS_START, CWRS_USER
  } cwrs_state_e;
  typedef struct packed {
    logic        start;
    logic [15:0] pc;
    logic        running;
  } cwrs_cpu_s;
endpackage

// File: core/cwrs_tick.sv
// Tick divider: one-cycle pulse every DIV cycles of the slow clock
`timescale 1ns/1ps
`default_nettype none
module cwrs_tick #(
  parameter int DIV = 64
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Tick out
  output logic      tick
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_nxt;
  always_comb begin
    tick_nxt = (cnt_r == 16'(DIV - 1));
    cnt_nxt  = tick_nxt ? 16'h0000 : cnt_r + 16'h0001;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

// File: core/cwrs_rtc.sv
// Free-running 24-bit real-time counter with a snapshot taken at measurement end
`timescale 1ns/1ps
`default_nettype none
module cwrs_rtc (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Control
  input  wire logic        period_tick,
  input  wire logic        snap,
  // Snapshot
  output logic [23:0]      rtc_snap
);
  logic [23:0] cnt_r;
  logic [23:0] cnt_nxt;
  logic [23:0] snap_nxt;
  always_comb begin
    cnt_nxt  = period_tick ? cnt_r + 24'h000001 : cnt_r;
    snap_nxt = snap ? cnt_r : rtc_snap;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r    <= 24'h000000;
      rtc_snap <= 24'h000000;
    end else begin
      cnt_r    <= cnt_nxt;
      rtc_snap <= snap_nxt;
    end
  end
endmodule
`default_nettype wire

// File: core/cwrs_top.sv
// Processor wake, reset and watchdog supervisor with AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cwrs_defines.svh"
module cwrs_top
  import cwrs_pkg::*;
#(
  parameter int PRESCALE  = `CWRS_PRESCALE,
  parameter int RTC_TICKS = `CWRS_RTC_TICKS
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Front end and processor
  input  wire logic        meas_done,
  input  wire logic        cpu_stop,
  input  wire logic        watchdog_clear_op,
  input  wire logic        watchdog_disable_cmd,
  input  wire logic        stand_alone,
  input  wire logic        select_reset_pin,
  output logic             meas_start,
  output logic             cfg_copy_start,
  output logic             cpu_start,
  output logic [15:0]      cpu_pc,
  output logic             chip_reset_n
);
  cwrs_state_e st_r, st_nxt;
  cwrs_cpu_s   cpu_r, cpu_nxt;
  logic [31:0] ctrl_r, ctrl_nxt, cfg0_r, cfg0_nxt, cfg1_r, cfg1_nxt;
  logic [23:0] status_r, status_nxt;
  logic [2:0]  wdog_r, wdog_nxt;
  logic        wdog_off_r, wdog_off_nxt, por_r, por_nxt, wdfire_r, wdfire_nxt;
  logic        pin_r, pin_nxt, btn_r, btn_nxt, reset_wake_r, reset_wake_nxt;
  logic [7:0]  conv_r, conv_nxt;
  logic        meas_r, meas_nxt, copy_r, copy_nxt, sleep_wake;
  logic        pre_tick, rtc_tick;
  logic [23:0] rtc_val;
  logic        aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt;
  logic [7:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic        wfull_r, wfull_nxt;
  logic        sleep_mode, wr_fire, pin_edge, wdog_fire;
  cwrs_tick #(.DIV(PRESCALE)) u_pre (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (pre_tick)
  );
  cwrs_tick #(.DIV(RTC_TICKS)) u_rtc_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (rtc_tick)
  );
  cwrs_rtc u_rtc (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .period_tick (rtc_tick),
    .snap        (meas_done),
    .rtc_snap    (rtc_val)
  );
  // AXI4-Lite slave: address and data held until both present
  always_comb begin
    aw_nxt  = aw_r;
    w_nxt   = w_r;
    awa_nxt = awa_r;
    wd_nxt  = wd_r;
    wfull_nxt = wfull_r;
    b_nxt   = b_r;
    r_nxt   = r_r;
    rd_nxt  = rd_r;
    if (s_axi_awvalid && !aw_r) begin
      aw_nxt  = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_r) begin
      w_nxt  = 1'b1;
      wd_nxt = s_axi_wdata;
      // Strobe kept with data: master may change it once data is taken
      wfull_nxt = (s_axi_wstrb == 4'hF);
    end
    wr_fire = aw_r && w_r && !b_r;
    if (wr_fire) begin
      aw_nxt = 1'b0;
      w_nxt  = 1'b0;
      b_nxt  = 1'b1;
    end else if (b_r && s_axi_bready) begin
      b_nxt = 1'b0;
    end
    if (s_axi_arvalid && !r_r) begin
      r_nxt = 1'b1;
      case (s_axi_araddr)
        `CWRS_OFF_CTRL:   rd_nxt = ctrl_r;
        `CWRS_OFF_CFG0:   rd_nxt = cfg0_r;
        `CWRS_OFF_CFG1:   rd_nxt = cfg1_r;
        `CWRS_OFF_STATUS: rd_nxt = {8'h00, status_r};
        `CWRS_OFF_RTC:    rd_nxt = {8'h00, rtc_val};
        `CWRS_OFF_WDOG:   rd_nxt = {28'h0000000, wdog_off_r, wdog_r};
        `CWRS_OFF_PC:     rd_nxt = {13'h0000, st_r, cpu_r.pc};
        default:          rd_nxt = 32'h00000000;
      endcase
    end else if (r_r && s_axi_rready) begin
      r_nxt = 1'b0;
    end
  end
  // Configuration writes; status bits are write-one-to-clear
  always_comb begin
    ctrl_nxt   = ctrl_r;
    cfg0_nxt   = cfg0_r;
    cfg1_nxt   = cfg1_r;
    if (wr_fire && wfull_r) begin
      case (awa_r)
        `CWRS_OFF_CTRL: ctrl_nxt = wd_r;
        `CWRS_OFF_CFG0: cfg0_nxt = wd_r;
        `CWRS_OFF_CFG1: cfg1_nxt = wd_r;
        default:        ctrl_nxt = ctrl_r;
      endcase
    end
  end
  assign sleep_mode = cfg1_r[`CWRS_CFG1_SLEEP];
  // Sequencer, watchdog and conversion counter
  always_comb begin
    st_nxt         = st_r;
    cpu_nxt        = cpu_r;
    cpu_nxt.start  = 1'b0;
    status_nxt     = status_r;
    wdog_nxt       = wdog_r;
    wdog_off_nxt   = wdog_off_r | watchdog_disable_cmd;
    pin_nxt        = select_reset_pin;
    pin_edge       = pin_r ^ select_reset_pin;
    // Press stays pending until idle, so a busy core never loses it
    btn_nxt        = (stand_alone && pin_r && !select_reset_pin) ||
                     (btn_r && st_r != CWRS_IDLE);
    por_nxt        = 1'b0;
    conv_nxt       = conv_r;
    meas_nxt       = 1'b0;
    copy_nxt       = 1'b0;
    sleep_wake     = 1'b0;
    reset_wake_nxt = reset_wake_r;
    wdfire_nxt     = 1'b0;
    if (pre_tick) begin
      if (conv_r >= cfg0_r[`CWRS_CFG0_CONV_LO +: 8] - 8'h01) begin
        conv_nxt   = 8'h00;
        sleep_wake = sleep_mode;
      end else begin
        conv_nxt = conv_r + 8'h01;
      end
    end
    wdog_fire = !wdog_off_r && wdog_r >= `CWRS_WDOG_LIMIT;
    if (watchdog_clear_op || pin_edge) begin
      wdog_nxt = 3'h0;
    end
    if (wr_fire && wfull_r && awa_r == `CWRS_OFF_STATUS) begin
      status_nxt = status_r & ~wd_r[23:0];
    end
    case (st_r)
      CWRS_IDLE: begin
        // Reset causes win over measurement end and sleep expiry
        if (por_r || btn_r || wdfire_r) begin
          reset_wake_nxt = 1'b1;
          st_nxt         = CWRS_ROM;
          cpu_nxt.pc     = `CWRS_ROM_ENTRY;
          cpu_nxt.start  = 1'b1;
          cpu_nxt.running = 1'b1;
        end else if (meas_done || sleep_wake) begin
          reset_wake_nxt = 1'b0;
          st_nxt         = CWRS_ROM;
          cpu_nxt.pc     = `CWRS_ROM_ENTRY;
          cpu_nxt.start  = 1'b1;
          cpu_nxt.running = 1'b1;
          if (sleep_wake) status_nxt[`CWRS_ST_SLEEP_WAKE] = 1'b1;
          if (meas_done) status_nxt[`CWRS_ST_MEAS_END] = 1'b1;
        end
      end
      CWRS_ROM: begin
        st_nxt = reset_wake_r ? CWRS_CFG : CWRS_START;
      end
      CWRS_CFG: begin
        copy_nxt = ctrl_r[`CWRS_CTRL_CFG_COPY];
        if (ctrl_r[`CWRS_CTRL_RST_USER]) begin
          st_nxt     = CWRS_USER;
          cpu_nxt.pc = `CWRS_USER_ENTRY;
          status_nxt[`CWRS_ST_RESET_CAUSE] = 1'b1;
        end else begin
          st_nxt  = CWRS_IDLE;
          cpu_nxt = '0;
        end
      end
      CWRS_START: begin
        // Sleep wake restarts counter and enters user code; no measurement launched
        meas_nxt = !sleep_mode;
        if (sleep_mode) conv_nxt = 8'h00;
        if (!sleep_mode && !watchdog_clear_op && !pin_edge)
          wdog_nxt = wdog_r + 3'h1;
        if (ctrl_r[`CWRS_CTRL_MEAS_USER] || sleep_mode) begin
          st_nxt     = CWRS_USER;
          cpu_nxt.pc = `CWRS_USER_ENTRY;
        end else begin
          st_nxt  = CWRS_IDLE;
          cpu_nxt = '0;
        end
      end
      CWRS_USER: begin
        if (cpu_stop) begin
          st_nxt  = CWRS_IDLE;
          cpu_nxt = '0;
        end
      end
      default: st_nxt = CWRS_IDLE;
    endcase
    if (wdog_fire) begin
      // Watchdog acts as a power-on reset of the sequencer
      wdfire_nxt = 1'b1;
      wdog_nxt   = 3'h0;
      st_nxt     = CWRS_IDLE;
      cpu_nxt    = '0;
      status_nxt[`CWRS_ST_WDOG] = 1'b1;
    end
    if (btn_r) status_nxt[`CWRS_ST_BUTTON] = 1'b1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Power-on: whole block resets, RAM lives outside
      st_r         <= CWRS_IDLE;
      cpu_r        <= '0;
      ctrl_r       <= 32'h00000000;
      cfg0_r       <= 32'h00010000;
      cfg1_r       <= 32'h00000000;
      status_r     <= 24'h000000;
      wdog_r       <= 3'h0;
      wdog_off_r   <= 1'b0;
      por_r        <= 1'b1;
      wdfire_r     <= 1'b0;
      pin_r        <= 1'b1;
      btn_r        <= 1'b0;
      reset_wake_r <= 1'b0;
      conv_r       <= 8'h00;
      meas_r       <= 1'b0;
      copy_r       <= 1'b0;
      aw_r         <= 1'b0;
      w_r          <= 1'b0;
      b_r          <= 1'b0;
      r_r          <= 1'b0;
      awa_r        <= 8'h00;
      wd_r         <= 32'h00000000;
      wfull_r      <= 1'b0;
      rd_r         <= 32'h00000000;
      chip_reset_n <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      cpu_r        <= cpu_nxt;
      ctrl_r       <= ctrl_nxt;
      cfg0_r       <= cfg0_nxt;
      cfg1_r       <= cfg1_nxt;
      status_r     <= status_nxt;
      wdog_r       <= wdog_nxt;
      wdog_off_r   <= wdog_off_nxt;
      por_r        <= por_nxt;
      wdfire_r     <= wdfire_nxt;
      pin_r        <= pin_nxt;
      btn_r        <= btn_nxt;
      reset_wake_r <= reset_wake_nxt;
      conv_r       <= conv_nxt;
      meas_r       <= meas_nxt;
      copy_r       <= copy_nxt;
      aw_r         <= aw_nxt;
      w_r          <= w_nxt;
      b_r          <= b_nxt;
      r_r          <= r_nxt;
      awa_r        <= awa_nxt;
      wd_r         <= wd_nxt;
      wfull_r      <= wfull_nxt;
      rd_r         <= rd_nxt;
      chip_reset_n <= !wdfire_nxt;
    end
  end
  always_comb begin
    s_axi_awready  = !aw_r;
    s_axi_wready   = !w_r;
    s_axi_bvalid   = b_r;
    s_axi_bresp    = 2'h0;
    s_axi_arready  = !r_r;
    s_axi_rvalid   = r_r;
    s_axi_rdata    = rd_r;
    s_axi_rresp    = 2'h0;
    meas_start     = meas_r;
    cfg_copy_start = copy_r;
    cpu_start      = cpu_r.start;
    cpu_pc         = cpu_r.pc;
  end
  chk_wdog_fires: assert property (@(posedge aclk) disable iff (!aresetn)
    wdog_fire |=> wdfire_r && wdog_r == 3'h0)
    else $error("watchdog did not reset");
  chk_wdog_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    wdog_fire |=> status_r[17])
    else $error("watchdog flag not set");
  chk_rom_first: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(cpu_r.running) |-> cpu_r.pc == 16'hF000)
    else $error("wake did not enter ROM");
  chk_reset_priority: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == CWRS_IDLE && (por_r || btn_r) && !wdog_fire |=> reset_wake_r)
    else $error("reset lost priority");
  chk_stop_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == CWRS_USER && cpu_stop && !wdog_fire |=> cpu_r == '0 && st_r == CWRS_IDLE)
    else $error("stop left state");
  chk_pin_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(select_reset_pin) && !wdog_fire |=> wdog_r == 3'h0)
    else $error("pin edge kept watchdog");
  chk_sleep_nomeas: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == CWRS_START && sleep_mode |=> !meas_start ##1 !meas_start)
    else $error("measurement in sleep");
  chk_wdog_off: assert property (@(posedge aclk) disable iff (!aresetn)
    wdog_off_r |=> chip_reset_n && !wdfire_r)
    else $error("disabled watchdog fired");
endmodule
`default_nettype wire

// File: verif/cwrs_partner.sv
// Front end and processor stand-in facing the supervisor
`timescale 1ns/1ps
`default_nettype none
`include "cwrs_defines.svh"
module cwrs_partner #(
  parameter int DLY = 20
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Bench control
  input  wire logic        kick,
  input  wire logic        run_en,
  input  wire logic        clr_en,
  // Supervisor side
  input  wire logic        meas_start,
  input  wire logic [15:0] cpu_pc,
  output logic             meas_done,
  output logic             cpu_stop,
  output logic             watchdog_clear_op
);
  int          meas_cnt;
  int          user_cnt;
  logic [15:0] pc_q;

  always @(posedge aclk) begin
    meas_done <= kick || (run_en && meas_cnt == 1);
    cpu_stop <= (user_cnt == 1);
    watchdog_clear_op <= clr_en && (user_cnt == 2);
    pc_q <= cpu_pc;
    // A pending result is dropped on reset, as the real front end loses it
    if (!aresetn || !run_en) meas_cnt <= 0;
    else if (meas_start === 1'b1) meas_cnt <= DLY;
    else if (meas_cnt > 0) meas_cnt <= meas_cnt - 1;
    if (!aresetn) user_cnt <= 0;
    else if (cpu_pc === `CWRS_USER_ENTRY && pc_q !== `CWRS_USER_ENTRY) user_cnt <= 3;
    else if (user_cnt > 0) user_cnt <= user_cnt - 1;
  end
endmodule
`default_nettype wire

// File: verif/cwrs_top_bench.sv
// Self-checking bench for the wake, reset and watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
`include "cwrs_defines.svh"
module cwrs_top_bench;
  localparam int PRE = 16;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        watchdog_disable_cmd = 1'b0;
  logic        stand_alone = 1'b0;
  logic        select_reset_pin = 1'b1;
  logic        kick = 1'b0;
  logic        run_en = 1'b0;
  logic        clr_en = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd, r1;
  logic        meas_done, cpu_stop, watchdog_clear_op, meas_start, cfg_copy_start;
  logic        cpu_start, chip_reset_n;
  logic [15:0] cpu_pc;
  wire logic   pt_rstn;
  int          fails = 0, n_compared = 0, n_meas = 0, n_cfg = 0, n_rst = 0, n_usr = 0;
  int          cyc = 0, t_last = 0, t_prev = 0, m0, c0, r0, i;

  assign pt_rstn = aresetn & chip_reset_n;
  always #2.5 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (meas_start === 1'b1) n_meas <= n_meas + 1;
    if (cfg_copy_start === 1'b1) n_cfg <= n_cfg + 1;
    if (cpu_pc === `CWRS_USER_ENTRY) n_usr <= n_usr + 1;
    if (cpu_start === 1'b1) begin
      t_prev <= t_last;
      t_last <= cyc;
    end
  end
  always @(negedge chip_reset_n) n_rst++;

  cwrs_top #(.PRESCALE(PRE), .RTC_TICKS(8)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas_done, .cpu_stop,
    .watchdog_clear_op, .watchdog_disable_cmd, .stand_alone, .select_reset_pin,
    .meas_start, .cfg_copy_start, .cpu_start, .cpu_pc, .chip_reset_n
  );
  cwrs_partner PARTNER (
    .aclk, .aresetn(pt_rstn), .kick, .run_en, .clr_en, .meas_start, .cpu_pc,
    .meas_done, .cpu_stop, .watchdog_clear_op
  );

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s: saw %h want %h", $time, m, seen, exp);
    end
  endtask
  task automatic tmo(input string m);
    $display("MISMATCH t=%0t %s wait expired", $time, m);
    fails++;
    finish_test();
  endtask
  // Kinds: 0 start, 1 user entry, 2 stopped, 3 chip reset, 4 measurement start
  task automatic wait_ev(input int k);
    for (int n = 0; n < 4000; n++) begin
      @(posedge aclk);
      #1;
      if ((k == 0 && cpu_start === 1'b1) || (k == 1 && cpu_pc === `CWRS_USER_ENTRY) ||
          (k == 2 && cpu_pc === 16'h0000) || (k == 3 && chip_reset_n === 1'b0) ||
          (k == 4 && meas_start === 1'b1)) return;
    end
    tmo("event");
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 500; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        chk(s_axi_bresp, 32'h0, "write response");
        s_axi_bready <= 1'b0;
        return;
      end
    end
    tmo("write");
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 500; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        chk(s_axi_rresp, 32'h0, "read response");
        s_axi_rready <= 1'b0;
        return;
      end
    end
    tmo("read");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e,
                        input string m);
    axi_rd(a);
    chk(rd & mk, e, m);
  endtask
  task automatic kick_once();
    @(posedge aclk);
    kick <= 1'b1;
    @(posedge aclk);
    kick <= 1'b0;
  endtask
  task automatic clr_status();
    axi_wr(`CWRS_OFF_STATUS, 32'h004F0000);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    chk(chip_reset_n, 32'h0, "chip reset during reset");
    aresetn <= 1'b1;
    wait_ev(0);
    chk(cpu_pc, `CWRS_ROM_ENTRY, "rom entry after reset");
    wait_ev(2);
    chk(n_cfg, 32'h0, "copy while disabled");
    rd_chk(`CWRS_OFF_CFG0, 32'hFFFFFFFF, 32'h00010000, "count reset");
    axi_wr(8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped read");
    $display("Test reset done");
    // Measurement wake without user code
    axi_wr(`CWRS_OFF_CTRL, 32'h00000002);
    c0 = n_usr;
    kick_once();
    wait_ev(0);
    chk(cpu_pc, `CWRS_ROM_ENTRY, "rom entry on wake");
    wait_ev(4);
    wait_ev(2);
    chk(n_usr - c0, 32'h0, "user code while disabled");
    axi_rd(`CWRS_OFF_RTC);
    r1 = rd;
    // Measurement wake with user code
    axi_wr(`CWRS_OFF_CTRL, 32'h00000006);
    clr_status();
    kick_once();
    wait_ev(0);
    wait_ev(4);
    wait_ev(1);
    wait_ev(2);
    rd_chk(`CWRS_OFF_STATUS, 32'h00410000, 32'h00010000, "end flag");
    axi_rd(`CWRS_OFF_RTC);
    chk(rd !== r1, 32'h1, "snapshot moved");
    axi_wr(`CWRS_OFF_STATUS, 32'h00010000);
    rd_chk(`CWRS_OFF_STATUS, 32'h00010000, 32'h0, "status clear");
    $display("Test measure done");
    // Four starts without clearing
    axi_wr(`CWRS_OFF_CTRL, 32'h00000007);
    clr_status();
    clr_en <= 1'b0;
    run_en <= 1'b1;
    m0 = n_meas;
    c0 = n_cfg;
    kick_once();
    wait_ev(3);
    run_en <= 1'b0;
    chk(n_meas - m0, 32'h4, "starts before watchdog");
    wait_ev(1);
    // Copy pulse leaves with the user entry; its count lands one edge later
    @(posedge aclk);
    #1;
    chk(n_cfg - c0, 32'h1, "copy after reset");
    rd_chk(`CWRS_OFF_STATUS, 32'h000A0000, 32'h000A0000, "watchdog flags");
    $display("Test watchdog done");
    // Cleared watchdog keeps running
    clr_en <= 1'b1;
    run_en <= 1'b1;
    r0 = n_rst;
    kick_once();
    for (i = 0; i < 6; i++) wait_ev(4);
    run_en <= 1'b0;
    chk(n_rst - r0, 32'h0, "reset despite clearing");
    wait_ev(2);
    $display("Test clear done");
    // Button reset
    clr_status();
    stand_alone <= 1'b1;
    c0 = n_cfg;
    @(posedge aclk);
    select_reset_pin <= 1'b0;
    wait_ev(0);
    wait_ev(1);
    @(posedge aclk);
    #1;
    chk(n_cfg - c0, 32'h1, "copy after button");
    rd_chk(`CWRS_OFF_STATUS, 32'h00040000, 32'h00040000, "button flag");
    select_reset_pin <= 1'b1;
    wait_ev(2);
    $display("Test button done");
    // Sleep: single-shot and later reinit are the stand-in's duty
    clr_status();
    axi_wr(`CWRS_OFF_CTRL, 32'h00000004);
    axi_wr(`CWRS_OFF_CFG0, 32'h00020000);
    m0 = n_meas;
    axi_wr(`CWRS_OFF_CFG1, 32'h00020000);
    wait_ev(0);
    wait_ev(1);
    wait_ev(0);
    // Start times are logged one edge after the pulse
    @(posedge aclk);
    #1;
    chk((t_last - t_prev >= PRE * 2) && (t_last - t_prev <= PRE * 2 + 8), 32'h1,
        "sleep period");
    axi_wr(`CWRS_OFF_CFG1, 32'h0);
    chk(n_meas - m0, 32'h0, "measured in sleep");
    rd_chk(`CWRS_OFF_STATUS, 32'h00400000, 32'h00400000, "sleep flag");
    wait_ev(2);
    $display("Test sleep done");
    // Disabled watchdog
    @(posedge aclk);
    watchdog_disable_cmd <= 1'b1;
    @(posedge aclk);
    watchdog_disable_cmd <= 1'b0;
    axi_wr(`CWRS_OFF_CTRL, 32'h00000006);
    clr_en <= 1'b0;
    run_en <= 1'b1;
    r0 = n_rst;
    kick_once();
    for (i = 0; i < 6; i++) wait_ev(4);
    run_en <= 1'b0;
    chk(n_rst - r0, 32'h0, "reset while disabled");
    $display("Test disable done");
    finish_test();
  end
endmodule
`default_nettype wire
